// file: scx_exec.sv
// Executor for the X-register, immediate variable and restart instructions
`timescale 1ns/1ns
`default_nettype none
module scx_exec #(
  parameter logic [7:0] HOST_ADDR = scx_pkg::DEF_HOST_ADDR,
  parameter logic [7:0] MODULE_ADDR = scx_pkg::DEF_MODULE_ADDR,
  parameter int VAR_DEPTH = scx_pkg::VAR_DEPTH
) (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic standalone_i,
  input wire logic pgm_valid_i,
  output logic pgm_ready_o,
  input wire logic [7:0] pgm_instr_i,
  input wire logic [7:0] pgm_type_i,
  input wire logic [7:0] pgm_bank_i,
  input wire logic [scx_pkg::VAL_W-1:0] pgm_value_i,
  input wire logic rx_valid_i,
  output logic rx_ready_o,
  input wire logic [7:0] rx_data_i,
  output logic tx_valid_o,
  input wire logic tx_ready_i,
  output logic [7:0] tx_data_o,
  output logic instr_done_o,
  output logic instr_err_o,
  output logic stack_clear_o,
  output logic pc_load_o,
  output logic [scx_pkg::VAL_W-1:0] pc_o,
  output logic [scx_pkg::VAL_W-1:0] x_reg_o,
  output logic [scx_pkg::FLAG_W-1:0] flags_o
);
  localparam int W = scx_pkg::VAL_W;

  // Variable index is eight bits wide, so more than 256 entries is unreachable
  if (VAR_DEPTH < 1 || VAR_DEPTH > scx_pkg::VAR_DEPTH) begin : g_bad_depth
    $error("scx_exec: VAR_DEPTH out of range");
  end

  scx_pkg::scx_state_type state;
  scx_pkg::scx_state_type next_state;

  // Current instruction fields
  logic [7:0] cur_addr;
  logic [7:0] cur_instr;
  logic [7:0] cur_type;
  logic [7:0] cur_bank;
  logic [W-1:0] cur_value;
  logic cur_direct;

  // Frame receive state
  logic [3:0] rx_idx;
  logic [7:0] rx_sum;
  logic frm_rdy;
  logic frm_chk_ok;

  // Reply state
  logic [3:0] tx_idx;
  logic [7:0] tx_sum;
  logic [7:0] rep_status;

  logic [W-1:0] x_reg;
  logic [scx_pkg::FLAG_W-1:0] flags;
  logic [W-1:0] pc;

  scx_var_if #(.W(W), .AW(scx_pkg::VAR_AW)) var_bus ();

  scx_var_mem #(.W(W), .DEPTH(VAR_DEPTH), .AW(scx_pkg::VAR_AW)) u_vars (
    .clock_i(clock_i),
    .bus(var_bus.store)
  );

  // Handshakes and launch conditions
  wire logic idle = (state == scx_pkg::ST_IDLE);
  assign pgm_ready_o = idle && standalone_i;
  assign rx_ready_o = idle && !standalone_i && !frm_rdy;
  wire logic go_pgm = pgm_valid_i && pgm_ready_o;
  wire logic rx_take = rx_valid_i && rx_ready_o;
  wire logic go_frame = idle && frm_rdy;
  wire logic addr_ok = (cur_addr == MODULE_ADDR);
  assign tx_valid_o = (state == scx_pkg::ST_REPLY);
  wire logic tx_take = tx_valid_o && tx_ready_i;
  wire logic tx_last = (tx_idx == scx_pkg::IDX_CHK);

  // Instruction decode
  wire logic is_xv = (cur_instr == scx_pkg::INSTR_XREG_VAR_CALC);
  wire logic is_imm = (cur_instr == scx_pkg::INSTR_VAR_IMMEDIATE_CALC);
  wire logic is_rst = (cur_instr == scx_pkg::INSTR_RESTART);
  wire scx_pkg::scx_op_type op = scx_pkg::scx_op_type'(cur_type[3:0]);
  wire logic type_in_range = (cur_type <= {4'h0, scx_pkg::OP_COMP});
  wire logic type_ok = type_in_range && !(is_imm && op == scx_pkg::OP_SWAP);
  wire logic calc_ok = (is_xv || is_imm) && type_ok;
  wire logic rst_ok = is_rst && !cur_direct;
  wire logic decode_bad = !calc_ok && !rst_ok;

  // Operands: X against variable, or variable against the immediate value
  wire logic [W-1:0] var_q = var_bus.rd_data;
  wire logic [W-1:0] opa = is_xv ? x_reg : var_q;
  wire logic [W-1:0] opb = is_xv ? var_q : cur_value;
  wire logic signed [W-1:0] sa = opa;
  wire logic signed [W-1:0] sb = opb;
  wire logic div_zero = (opb == '0);

  // Division by zero leaves the target as it was rather than inventing a value
  wire logic signed [W-1:0] q_div = div_zero ? sa : (sa / sb);
  wire logic signed [W-1:0] q_mod = div_zero ? sa : (sa % sb);

  // Result selection; NOT always inverts the variable, LOAD always takes the second operand
  wire logic [W-1:0] result =
    (op == scx_pkg::OP_ADD) ? opa + opb :
    (op == scx_pkg::OP_SUB) ? opa - opb :
    (op == scx_pkg::OP_MUL) ? opa * opb :
    (op == scx_pkg::OP_DIV) ? q_div :
    (op == scx_pkg::OP_MOD) ? q_mod :
    (op == scx_pkg::OP_AND) ? opa & opb :
    (op == scx_pkg::OP_OR) ? opa | opb :
    (op == scx_pkg::OP_XOR) ? opa ^ opb :
    (op == scx_pkg::OP_NOT) ? ~var_q :
    (op == scx_pkg::OP_LOAD) ? opb :
    (op == scx_pkg::OP_SWAP) ? var_q :
    opa;

  // Write targets; compare writes nothing
  wire logic exec = (state == scx_pkg::ST_EXEC);
  wire logic is_comp = (op == scx_pkg::OP_COMP);
  wire logic x_wr = exec && is_xv && !is_comp;
  wire logic var_wr = exec && ((is_imm && !is_comp) || (is_xv && op == scx_pkg::OP_SWAP));

  // Variable store access: read issued in decode, data used in exec
  assign var_bus.rd_en = (state == scx_pkg::ST_DECODE);
  assign var_bus.addr = cur_bank;
  assign var_bus.wr_en = var_wr;
  assign var_bus.wr_data = is_xv ? x_reg : result;

  // Flags after the operation
  wire logic [scx_pkg::FLAG_W-1:0] comp_flags = {sa < sb, sa > sb, opa == opb, opa == opb};
  wire logic [scx_pkg::FLAG_W-1:0] next_flags = is_comp ? comp_flags : {flags[3:1], result == '0};

  // Status to send when a reply begins
  wire logic [7:0] next_status =
    idle ? scx_pkg::STATUS_BAD_CHECKSUM :
    exec ? scx_pkg::STATUS_OK :
    (is_rst || !(is_xv || is_imm)) ? scx_pkg::STATUS_BAD_COMMAND :
    scx_pkg::STATUS_BAD_TYPE;

  // Next reply byte, value most significant first
  wire logic [3:0] tx_nidx = tx_idx + 4'h1;
  wire logic [7:0] tx_byte =
    (tx_nidx == scx_pkg::IDX_SECOND) ? MODULE_ADDR :
    (tx_nidx == scx_pkg::IDX_STATUS_TYPE) ? rep_status :
    (tx_nidx == scx_pkg::IDX_BANK_INSTR) ? cur_instr :
    (tx_nidx == scx_pkg::IDX_VAL3) ? cur_value[31:24] :
    (tx_nidx == scx_pkg::IDX_VAL2) ? cur_value[23:16] :
    (tx_nidx == scx_pkg::IDX_VAL1) ? cur_value[15:8] :
    (tx_nidx == scx_pkg::IDX_VAL0) ? cur_value[7:0] :
    tx_sum;
  wire logic enter_reply = (state != scx_pkg::ST_REPLY) && (next_state == scx_pkg::ST_REPLY);

  // Pulses for the program sequencer outside
  assign stack_clear_o = (state == scx_pkg::ST_CLEAR);
  assign pc_load_o = (state == scx_pkg::ST_LOAD);
  assign instr_done_o = exec || pc_load_o || ((state == scx_pkg::ST_DECODE) && decode_bad);
  assign instr_err_o = (state == scx_pkg::ST_DECODE) && decode_bad;
  assign pc_o = pc;
  assign x_reg_o = x_reg;
  assign flags_o = flags;

  // Sequencer next state
  always_comb begin
    next_state = state;
    case (state)
      scx_pkg::ST_IDLE: begin
        if (go_pgm) begin
          next_state = scx_pkg::ST_DECODE;
        end else if (go_frame && addr_ok) begin
          next_state = frm_chk_ok ? scx_pkg::ST_DECODE : scx_pkg::ST_REPLY;
        end
      end
      scx_pkg::ST_DECODE: begin
        if (rst_ok) begin
          next_state = scx_pkg::ST_CLEAR;
        end else if (calc_ok) begin
          next_state = scx_pkg::ST_EXEC;
        end else begin
          next_state = cur_direct ? scx_pkg::ST_REPLY : scx_pkg::ST_IDLE;
        end
      end
      scx_pkg::ST_EXEC: begin
        next_state = cur_direct ? scx_pkg::ST_REPLY : scx_pkg::ST_IDLE;
      end
      scx_pkg::ST_CLEAR: begin
        next_state = scx_pkg::ST_LOAD;
      end
      scx_pkg::ST_LOAD: begin
        next_state = scx_pkg::ST_IDLE;
      end
      scx_pkg::ST_REPLY: begin
        if (tx_take && tx_last) begin
          next_state = scx_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = scx_pkg::ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= scx_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Frame byte counter and running sum; a mode change drops a partial frame
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_idx <= scx_pkg::IDX_ADDR;
      rx_sum <= 8'h00;
      frm_rdy <= 1'b0;
      frm_chk_ok <= 1'b0;
    end else if (standalone_i || go_frame) begin
      rx_idx <= scx_pkg::IDX_ADDR;
      rx_sum <= 8'h00;
      frm_rdy <= 1'b0;
    end else if (rx_take) begin
      rx_idx <= (rx_idx == scx_pkg::IDX_CHK) ? scx_pkg::IDX_ADDR : rx_idx + 4'h1;
      rx_sum <= (rx_idx == scx_pkg::IDX_CHK) ? 8'h00 : rx_sum + rx_data_i;
      frm_rdy <= (rx_idx == scx_pkg::IDX_CHK);
      frm_chk_ok <= (rx_sum == rx_data_i);
    end
  end

  // Instruction fields, from the program port or byte by byte from a frame
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cur_addr <= 8'h00;
      cur_instr <= 8'h00;
      cur_type <= 8'h00;
      cur_bank <= 8'h00;
      cur_value <= '0;
      cur_direct <= 1'b0;
    end else if (go_pgm) begin
      cur_addr <= MODULE_ADDR;
      cur_instr <= pgm_instr_i;
      cur_type <= pgm_type_i;
      cur_bank <= pgm_bank_i;
      cur_value <= pgm_value_i;
      cur_direct <= 1'b0;
    end else if (rx_take) begin
      cur_direct <= 1'b1;
      case (rx_idx)
        scx_pkg::IDX_ADDR: cur_addr <= rx_data_i;
        scx_pkg::IDX_SECOND: cur_instr <= rx_data_i;
        scx_pkg::IDX_STATUS_TYPE: cur_type <= rx_data_i;
        scx_pkg::IDX_BANK_INSTR: cur_bank <= rx_data_i;
        scx_pkg::IDX_CHK: cur_value <= cur_value;
        default: cur_value <= {cur_value[23:0], rx_data_i};
      endcase
    end
  end

  // Working registers; restart wipes them before the counter is loaded
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      x_reg <= '0;
      flags <= '0;
      pc <= '0;
    end else if (stack_clear_o) begin
      x_reg <= '0;
      flags <= '0;
    end else if (pc_load_o) begin
      pc <= cur_value;
    end else if (exec) begin
      x_reg <= x_wr ? result : x_reg;
      flags <= next_flags;
    end
  end

  // Reply serializer; checksum accumulates as bytes are loaded
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_idx <= scx_pkg::IDX_ADDR;
      tx_sum <= 8'h00;
      tx_data_o <= 8'h00;
      rep_status <= 8'h00;
    end else if (enter_reply) begin
      tx_idx <= scx_pkg::IDX_ADDR;
      tx_sum <= HOST_ADDR;
      tx_data_o <= HOST_ADDR;
      rep_status <= next_status;
    end else if (tx_take && !tx_last) begin
      tx_idx <= tx_nidx;
      tx_sum <= tx_sum + tx_byte;
      tx_data_o <= tx_byte;
    end
  end
endmodule : scx_exec
`default_nettype wire

// file: scx_exec_properties.sv
// Concurrent checks on the executor program, restart and mode ports
`timescale 1ns/1ns
`default_nettype none
module scx_exec_properties (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic standalone_i,
  input wire logic pgm_valid_i,
  input wire logic pgm_ready_o,
  input wire logic [7:0] pgm_instr_i,
  input wire logic [7:0] pgm_type_i,
  input wire logic [scx_pkg::VAL_W-1:0] pgm_value_i,
  input wire logic tx_valid_o,
  input wire logic instr_done_o,
  input wire logic instr_err_o,
  input wire logic stack_clear_o,
  input wire logic pc_load_o,
  input wire logic [scx_pkg::VAL_W-1:0] pc_o,
  input wire logic [scx_pkg::VAL_W-1:0] x_reg_o,
  input wire logic [scx_pkg::FLAG_W-1:0] flags_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);

  // Program port acceptance and the opening steps of a restart
  wire logic take = pgm_valid_i && pgm_ready_o;
  wire logic is_calc = pgm_instr_i == scx_pkg::INSTR_XREG_VAR_CALC || pgm_instr_i == scx_pkg::INSTR_VAR_IMMEDIATE_CALC;
  sequence take_restart_s;
    take && pgm_instr_i == scx_pkg::INSTR_RESTART;
  endsequence
  sequence clear_then_load_s;
    (stack_clear_o && !pc_load_o) ##1 (pc_load_o && !stack_clear_o);
  endsequence

  restart_order_a: assert property (take_restart_s |-> ##2 clear_then_load_s)
    else $error("restart did not clear stacks before loading the counter");
  restart_pc_a: assert property (take_restart_s |-> ##4 pc_o == $past(pgm_value_i, 4))
    else $error("restart address not loaded");
  restart_regs_a: assert property (take_restart_s |-> ##4 (x_reg_o == '0 && flags_o == '0))
    else $error("restart left working registers set");
  load_cause_a: assert property (pc_load_o |-> $past(stack_clear_o))
    else $error("counter load without preceding clear");
  clear_mode_a: assert property (stack_clear_o |-> standalone_i)
    else $error("stack clear in direct mode");
  ready_mode_a: assert property (pgm_ready_o |-> standalone_i && !tx_valid_o)
    else $error("program port ready outside standalone idle");
  calc_done_a: assert property (take && is_calc && pgm_type_i < 8'h0a |-> ##1 !instr_done_o ##1 (instr_done_o && !instr_err_o))
    else $error("calculation not finished in its cycle");
  imm_swap_a: assert property (take && pgm_instr_i == scx_pkg::INSTR_VAR_IMMEDIATE_CALC && pgm_type_i == 8'h0a |-> ##1 (instr_done_o && instr_err_o))
    else $error("immediate exchange not refused");
  comp_keep_a: assert property (take && pgm_instr_i == scx_pkg::INSTR_XREG_VAR_CALC && pgm_type_i == 8'h0b |-> ##3 $stable(x_reg_o))
    else $error("compare changed the X register");
endmodule : scx_exec_properties
bind scx_exec scx_exec_properties i_props (.clock_i(clock_i), .arst_n_i(arst_n_i), .standalone_i(standalone_i),
  .pgm_valid_i(pgm_valid_i), .pgm_ready_o(pgm_ready_o), .pgm_instr_i(pgm_instr_i), .pgm_type_i(pgm_type_i),
  .pgm_value_i(pgm_value_i), .tx_valid_o(tx_valid_o), .instr_done_o(instr_done_o), .instr_err_o(instr_err_o),
  .stack_clear_o(stack_clear_o), .pc_load_o(pc_load_o), .pc_o(pc_o), .x_reg_o(x_reg_o), .flags_o(flags_o));
`default_nettype wire

// file: scx_host_model.sv
// Host controller model: sends command frames and collects the replies
`timescale 1ns/1ns
`default_nettype none
module scx_host_model (
  input wire logic clock_i,
  output logic rx_valid_o,
  input wire logic rx_ready_i,
  output logic [7:0] rx_data_o,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  input wire logic [7:0] tx_data_i
);
  logic [7:0] rep [9];
  int hung = 0;
  int stall = 0;
  initial begin
    rx_valid_o = 1'b0;
    rx_data_o = 8'h00;
    tx_ready_o = 1'b0;
  end

  // Waits at falling edges for ready (sel low) or reply valid (sel high); bounded so a dead link cannot hang the run
  task automatic wait_for(input logic sel);
    int n;
    n = 0;
    while ((sel ? tx_valid_i : rx_ready_i) !== 1'b1 && n < 60) begin
      @(negedge clock_i);
      n++;
    end
    if (n == 60) hung++;
  endtask : wait_for

  // Bytes go back to back with valid held high, the hardest case for the receiver
  task automatic frame(input logic [7:0] ins, typ, bank, input logic [31:0] val, input logic bad);
    logic [7:0] b [9];
    b = '{scx_pkg::DEF_MODULE_ADDR, ins, typ, bank, val[31:24], val[23:16], val[15:8], val[7:0], 8'h00};
    for (int i = 0; i < 8; i++) b[8] += b[i];
    b[8] ^= {7'h00, bad};
    @(negedge clock_i);
    rx_valid_o = 1'b1;
    for (int i = 0; i < 9; i++) begin
      rx_data_o = b[i];
      wait_for(1'b0);
      @(posedge clock_i);
      @(negedge clock_i);
    end
    // Released line shows the inverse so a stale byte cannot pass
    rx_valid_o = 1'b0;
    rx_data_o = ~b[8];
    for (int i = 0; i < 9; i++) begin
      repeat (stall) @(negedge clock_i);
      tx_ready_o = 1'b1;
      wait_for(1'b1);
      rep[i] = tx_data_i;
      @(posedge clock_i);
      @(negedge clock_i);
      if (stall > 0) tx_ready_o = 1'b0;
    end
    if (stall == 0) tx_ready_o = 1'b0;
  endtask : frame
endmodule : scx_host_model
`default_nettype wire

// file: scx_pkg.sv
// Constants and types shared by the standalone calculation and restart executor
package scx_pkg;
  // Operand and variable store geometry
  localparam int VAL_W = 32;
  localparam int VAR_DEPTH = 256;
  localparam int VAR_AW = 8;

  // Instruction numbers (44, 45, 48)
  localparam logic [7:0] INSTR_XREG_VAR_CALC = 8'h2c;
  localparam logic [7:0] INSTR_VAR_IMMEDIATE_CALC = 8'h2d;
  localparam logic [7:0] INSTR_RESTART = 8'h30;

  // Reply status codes
  localparam logic [7:0] STATUS_OK = 8'h64;
  localparam logic [7:0] STATUS_BAD_CHECKSUM = 8'h01;
  localparam logic [7:0] STATUS_BAD_COMMAND = 8'h02;
  localparam logic [7:0] STATUS_BAD_TYPE = 8'h03;

  // Default link addresses
  localparam logic [7:0] DEF_HOST_ADDR = 8'h02;
  localparam logic [7:0] DEF_MODULE_ADDR = 8'h01;

  // Byte positions inside a nine byte frame, command and reply alike
  localparam logic [3:0] IDX_ADDR = 4'h0;
  localparam logic [3:0] IDX_SECOND = 4'h1;
  localparam logic [3:0] IDX_STATUS_TYPE = 4'h2;
  localparam logic [3:0] IDX_BANK_INSTR = 4'h3;
  localparam logic [3:0] IDX_VAL3 = 4'h4;
  localparam logic [3:0] IDX_VAL2 = 4'h5;
  localparam logic [3:0] IDX_VAL1 = 4'h6;
  localparam logic [3:0] IDX_VAL0 = 4'h7;
  localparam logic [3:0] IDX_CHK = 4'h8;

  // Condition flag positions
  localparam int FLAG_ZERO = 0;
  localparam int FLAG_EQ = 1;
  localparam int FLAG_GT = 2;
  localparam int FLAG_LT = 3;
  localparam int FLAG_W = 4;

  // Operation codes carried in the type field
  typedef enum logic [3:0] {
    OP_ADD = 4'h0,
    OP_SUB = 4'h1,
    OP_MUL = 4'h2,
    OP_DIV = 4'h3,
    OP_MOD = 4'h4,
    OP_AND = 4'h5,
    OP_OR = 4'h6,
    OP_XOR = 4'h7,
    OP_NOT = 4'h8,
    OP_LOAD = 4'h9,
    OP_SWAP = 4'ha,
    OP_COMP = 4'hb
  } scx_op_type;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_DECODE = 3'h1,
    ST_EXEC = 3'h2,
    ST_CLEAR = 3'h3,
    ST_LOAD = 3'h4,
    ST_REPLY = 3'h5
  } scx_state_type;
endpackage : scx_pkg

// file: scx_var_if.sv
// Interface between the executor and its user variable store
`timescale 1ns/1ns
`default_nettype none
interface scx_var_if #(
  parameter int W = 32,
  parameter int AW = 8
);
  logic rd_en;
  logic wr_en;
  logic [AW-1:0] addr;
  logic [W-1:0] wr_data;
  logic [W-1:0] rd_data;

  modport ctrl (output rd_en, output wr_en, output addr, output wr_data, input rd_data);
  modport store (input rd_en, input wr_en, input addr, input wr_data, output rd_data);
endinterface : scx_var_if
`default_nettype wire

// file: scx_var_mem.sv
// User variable store with registered read data
`timescale 1ns/1ns
`default_nettype none
module scx_var_mem #(
  parameter int W = 32,
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  input wire logic clock_i,
  scx_var_if.store bus
);
  logic [W-1:0] mem [DEPTH];

  // Refuse a depth that the address cannot reach
  if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_bad_depth
    $error("scx_var_mem: DEPTH out of range");
  end

  // Array has no reset so it maps to block RAM; read data lags the request by one edge
  always_ff @(posedge clock_i) begin
    if (bus.wr_en) begin
      mem[bus.addr] <= bus.wr_data;
    end
    if (bus.rd_en) begin
      bus.rd_data <= mem[bus.addr];
    end
  end
endmodule : scx_var_mem
`default_nettype wire

// file: tb.sv
// Self-checking bench for the calculation and restart executor
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clock_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic standalone = 1'b1;
  logic pgm_valid = 1'b0;
  logic [7:0] pgm_instr = 8'h00;
  logic [7:0] pgm_type = 8'h00;
  logic [7:0] pgm_bank = 8'h00;
  logic [31:0] pgm_value = 32'h0;
  logic pgm_ready, rx_valid, rx_ready, tx_valid, tx_ready, done, err, clr, pld;
  logic [7:0] rx_data, tx_data;
  logic [31:0] pc, xr;
  logic [3:0] flags;
  int failures = 0;
  int compares = 0;

  always #2 clock_i = ~clock_i;

  scx_exec i_dut (.clock_i(clock_i), .arst_n_i(arst_n_i), .standalone_i(standalone), .pgm_valid_i(pgm_valid),
    .pgm_ready_o(pgm_ready), .pgm_instr_i(pgm_instr), .pgm_type_i(pgm_type), .pgm_bank_i(pgm_bank),
    .pgm_value_i(pgm_value), .rx_valid_i(rx_valid), .rx_ready_o(rx_ready), .rx_data_i(rx_data),
    .tx_valid_o(tx_valid), .tx_ready_i(tx_ready), .tx_data_o(tx_data), .instr_done_o(done), .instr_err_o(err),
    .stack_clear_o(clr), .pc_load_o(pld), .pc_o(pc), .x_reg_o(xr), .flags_o(flags));
  scx_host_model i_host (.clock_i(clock_i), .rx_valid_o(rx_valid), .rx_ready_i(rx_ready), .rx_data_o(rx_data),
    .tx_valid_i(tx_valid), .tx_ready_o(tx_ready), .tx_data_i(tx_data));

  task automatic conclude();
    if (failures == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string name, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Expected result; operands kept positive so signedness cannot matter
  function automatic logic [31:0] calc(input logic [3:0] op, input logic [31:0] a, b);
    case (op)
      4'h0: return a + b;
      4'h1: return a - b;
      4'h2: return a * b;
      4'h3: return (b == 0) ? a : a / b;
      4'h4: return (b == 0) ? a : a % b;
      4'h5: return a & b;
      4'h6: return a | b;
      4'h7: return a ^ b;
      4'h8: return ~b;
      default: return b;
    endcase
  endfunction : calc

  // One program instruction; fields held until taken, then inverted
  task automatic exec(input logic [7:0] ins, typ, bank, input logic [31:0] val, output logic e);
    int n;
    @(negedge clock_i);
    pgm_valid = 1'b1;
    {pgm_instr, pgm_type, pgm_bank, pgm_value} = {ins, typ, bank, val};
    for (n = 0; pgm_ready !== 1'b1 && n < 60; n++) @(negedge clock_i);
    // A port that never opens is a failure, not a silent skip
    if (n == 60) begin
      failures++;
      conclude();
    end
    @(posedge clock_i);
    @(negedge clock_i);
    pgm_valid = 1'b0;
    {pgm_instr, pgm_type, pgm_bank, pgm_value} = ~{ins, typ, bank, val};
    for (n = 0; done !== 1'b1 && n < 60; n++) @(negedge clock_i);
    if (n == 60) begin
      failures++;
      conclude();
    end
    e = err;
    @(negedge clock_i);
  endtask : exec

  task automatic t_xreg();
    logic [31:0] xm, vm;
    logic e;
    vm = 32'h7;
    xm = 32'h7;
    exec(8'h2d, 8'h09, 8'hff, vm, e);
    exec(8'h2c, 8'h09, 8'hff, 32'hffffffff, e);
    for (int op = 0; op < 10; op++) begin
      exec(8'h2c, 8'(op), 8'hff, 32'hdeadbeef, e);
      xm = calc(4'(op), xm, vm);
      chk("x op", xr, xm);
      chk("zero flag", flags[0], xm == 32'h0);
    end
    exec(8'h2d, 8'h09, 8'hff, 32'h1234, e);
    exec(8'h2c, 8'h0a, 8'hff, 32'h0, e);
    chk("x swap", xr, 32'h1234);
    exec(8'h2c, 8'h09, 8'hff, 32'h0, e);
    chk("var swap", xr, 32'h7);
    for (int i = 0; i < 3; i++) begin
      vm = (i == 0) ? 32'h7 : (i == 1) ? 32'h2000 : 32'h3;
      exec(8'h2d, 8'h09, 8'h10, vm, e);
      exec(8'h2c, 8'h0b, 8'h10, 32'h0, e);
      chk("x cmp", xr, 32'h7);
      chk("cmp flags", flags[3:1], {vm > 7, vm < 7, vm == 7});
    end
  endtask : t_xreg

  task automatic t_imm();
    logic [31:0] vm;
    logic e;
    vm = 32'h64;
    exec(8'h2d, 8'h09, 8'h00, vm, e);
    for (int op = 0; op < 9; op++) begin
      exec(8'h2d, 8'(op), 8'h00, 32'h5, e);
      vm = calc(4'(op), vm, (op == 8) ? vm : 32'h5);
      chk("x untouched", xr, 32'h7);
      exec(8'h2c, 8'h09, 8'h00, 32'h0, e);
      chk("var imm", xr, vm);
      exec(8'h2c, 8'h09, 8'hff, 32'h0, e);
    end
    exec(8'h2d, 8'h0a, 8'h00, 32'h5, e);
    chk("swap refused", e, 1'b1);
    exec(8'h2d, 8'h0b, 8'h00, 32'h9, e);
    chk("imm cmp", flags[3:1], 3'b100);
  endtask : t_imm

  task automatic t_restart();
    logic e;
    exec(8'h30, 8'h5a, 8'h33, 32'ha, e);
    chk("restart pc", pc, 32'ha);
    chk("restart x", xr, 32'h0);
    exec(8'h30, 8'h00, 8'h00, 32'hfffffffe, e);
    chk("restart pc2", pc, 32'hfffffffe);
  endtask : t_restart

  task automatic t_direct();
    logic [7:0] st [4] = '{8'h64, 8'h64, 8'h02, 8'h01};
    logic [7:0] ins [4] = '{8'h2c, 8'h2d, 8'h30, 8'h2c};
    logic [31:0] vals [4] = '{32'h0, 32'h1388, 32'ha, 32'h0};
    logic [7:0] sum;
    @(negedge clock_i);
    standalone = 1'b0;
    // Variable 0 holds all ones from the immediate scenario, so no unknown operand enters
    for (int i = 0; i < 4; i++) begin
      i_host.stall = i;
      case (i)
        0: i_host.frame(8'h2c, 8'h01, 8'h00, 32'h0, 1'b0);
        1: i_host.frame(8'h2d, 8'h01, 8'h00, 32'h1388, 1'b0);
        2: i_host.frame(8'h30, 8'h00, 8'h00, 32'ha, 1'b0);
        default: i_host.frame(8'h2c, 8'h01, 8'h1b, 32'h0, 1'b1);
      endcase
      chk("reply status", i_host.rep[2], st[i]);
      chk("reply hosts", {i_host.rep[0], i_host.rep[1]}, 16'h0201);
      sum = 8'h00;
      for (int k = 0; k < 8; k++) sum += i_host.rep[k];
      chk("reply sum", i_host.rep[8], sum);
      chk("reply instr", i_host.rep[3], ins[i]);
      chk("value msb first", {i_host.rep[4], i_host.rep[5], i_host.rep[6], i_host.rep[7]}, vals[i]);
      if (i == 0) chk("direct x", xr, 32'h1);
    end
    chk("direct restart pc", pc, 32'hfffffffe);
    chk("link hangs", 32'(i_host.hung), 32'h0);
  endtask : t_direct

  initial begin
    repeat (3) @(posedge clock_i);
    @(negedge clock_i);
    arst_n_i = 1'b1;
    t_xreg();
    t_imm();
    t_restart();
    t_direct();
    conclude();
  end
endmodule : tb
`default_nettype wire
